// ---- include/pio_xlate_regs.vh ----
`ifndef PIO_XLATE_REGS_VH
`define PIO_XLATE_REGS_VH
// apb register byte offsets
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_LAST_ADDR   12'h008
`define OFF_LOCAL_CNT   12'h00c
`define OFF_DEVREG_BASE 12'h040
`define OFF_DEVREG_TOP  12'h07c
// control word fields
`define CTRL_NODE_LSB   0
`define CTRL_NODE_W     11
// device register fields: [11:0] offset, [12] memory space select
`define DEV_OFF_LSB     0
`define DEV_OFF_W       12
`define DEV_MEM_BIT     12
`define DEV_RESET       13'h0000
// processor address fields
`define NODE_MSB        48
`define NODE_LSB        38
`define SEL_MSB         27
`define SEL_LSB         20
`define WIN_MSB         23
`define WIN_LSB         20
`define LOW_MSB         19
`define XLATE_LSB       20
`endif

// ---- logic/pio_address_translator.v ----
// Operation
// - bus addresses for pio are 32 bits, single address cycle only
// - space select set gives a memory request, clear gives an i/o request
// - device register offset replaces bits 31 to 20 of the pio address
// - node hub compares address bits 48 to 38 with its own node number
// - match: request goes over the hub io link to the local bridge
// - mismatch: request goes across the network to the owning remote hub
// - bridge drives the translated address, not the processor address
// - window bits 23 to 20, above bit 19, pick the device register
// - widget/window bits dropped, offset placed above low 20 bits
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "pio_xlate_regs.vh"
module pio_address_translator #(
  parameter ADDR_W = 50,
  parameter WIN_N  = 16
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              req_valid,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire              req_write,
  input  wire [3:0]        req_be,
  input  wire [31:0]       req_wdata,
  output reg               req_ready,
  output reg               rsp_valid,
  output reg  [31:0]       rsp_rdata,
  output reg               remote_valid,
  output reg  [ADDR_W-1:0] remote_addr,
  output reg               remote_write,
  output reg  [3:0]        remote_be,
  output reg  [31:0]       remote_wdata,
  input  wire              remote_ack,
  input  wire [31:0]       remote_rdata,
  output reg               pcix_valid,
  output reg  [31:0]       pcix_addr,
  output reg               pcix_mem,
  output reg               pcix_write,
  output reg  [3:0]        pcix_be,
  output reg  [31:0]       pcix_wdata,
  input  wire              pcix_ack,
  input  wire [31:0]       pcix_rdata
);
  ////////////////////////////////////////////////////////////////////////
  // router states, one-hot
  localparam ST_IDLE   = 3'b001;
  localparam ST_LOCAL  = 3'b010;
  localparam ST_REMOTE = 3'b100;

  reg [2:0]                  state_r;
  reg [`CTRL_NODE_W-1:0]     node_number_r;
  // last translated address kept for software to inspect
  reg [31:0]                 last_addr_r;
  // counters wrap silently; software must read them as differences
  reg [15:0]                 local_cnt_r;
  reg [15:0]                 remote_cnt_r;
  reg [`DEV_MEM_BIT:0]       devreg_r [0:WIN_N-1];

  wire [`CTRL_NODE_W-1:0] req_node = req_addr[`NODE_MSB:`NODE_LSB];
  wire is_local = (req_node == node_number_r);
  wire [3:0] win_idx = req_addr[`WIN_MSB:`WIN_LSB];
  wire [`DEV_MEM_BIT:0] sel_dev = devreg_r[win_idx];
  wire [`DEV_OFF_W-1:0] win_off = sel_dev[`DEV_OFF_W-1:0];
  wire                  win_mem = sel_dev[`DEV_MEM_BIT];
  wire [`LOW_MSB:0]     low_bits = req_addr[`LOW_MSB:0];
  // upper address bits dropped so only a 32-bit single cycle address leaves for the local bridge
  wire [31:0] xlate_addr = {win_off, low_bits};

  ////////////////////////////////////////////////////////////////////////
  // one wait state, then pready for one cycle; writes land on the edge that
  // ends the transfer, so the control and device registers never change under a pending access
  wire apb_acc  = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire apb_wr   = apb_done & pwrite;
  wire dev_hit  = (paddr >= `OFF_DEVREG_BASE) && (paddr <= `OFF_DEVREG_TOP)
                  && (paddr[1:0] == 2'b00);
  wire [3:0] dev_idx = paddr[5:2];
  wire ctrl_hit = (paddr == `OFF_CTRL);
  wire map_hit  = dev_hit || ctrl_hit || (paddr == `OFF_STATUS)
                  || (paddr == `OFF_LAST_ADDR) || (paddr == `OFF_LOCAL_CNT);
  reg  [31:0] rd_nxt;

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < WIN_N; g = g + 1) begin : g_dev
      always @(posedge mclk) begin
        if (rst) begin
          devreg_r[g] <= `DEV_RESET;
        end else if (apb_wr && dev_hit && dev_idx == g) begin
          devreg_r[g] <= pwdata[`DEV_MEM_BIT:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (dev_hit) begin
      rd_nxt = {19'h0_0000, devreg_r[dev_idx]};
    end else begin
      case (paddr)
        `OFF_CTRL:      rd_nxt = {21'h00_0000, node_number_r};
        `OFF_STATUS:    rd_nxt = {13'h0000, state_r, remote_cnt_r};
        `OFF_LAST_ADDR: rd_nxt = last_addr_r;
        `OFF_LOCAL_CNT: rd_nxt = {16'h0000, local_cnt_r};
        default:        rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // unmapped reads return zero with pslverr; unmapped writes change nothing
  always @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~map_hit;
      prdata  <= apb_acc ? rd_nxt : 32'h0000_0000;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      node_number_r <= {`CTRL_NODE_W{1'b0}};
    end else if (apb_wr && ctrl_hit) begin
      node_number_r <= pwdata[`CTRL_NODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= 32'h0000_0000;
      remote_valid <= 1'b0;
      remote_addr  <= {ADDR_W{1'b0}};
      remote_write <= 1'b0;
      remote_be    <= 4'h0;
      remote_wdata <= 32'h0000_0000;
      pcix_valid   <= 1'b0;
      pcix_addr    <= 32'h0000_0000;
      pcix_mem     <= 1'b0;
      pcix_write   <= 1'b0;
      pcix_be      <= 4'h0;
      pcix_wdata   <= 32'h0000_0000;
      last_addr_r  <= 32'h0000_0000;
      local_cnt_r  <= 16'h0000;
      remote_cnt_r <= 16'h0000;
    end else begin
      // req_ready and rsp_valid are one-cycle pulses, so a req_valid held past the req_ready cycle is retaken
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req_valid && !req_ready) begin
            if (is_local) begin
              pcix_valid  <= 1'b1;
              pcix_addr   <= xlate_addr;
              last_addr_r <= xlate_addr;
              pcix_mem    <= win_mem;
              pcix_write  <= req_write;
              pcix_be     <= req_be;
              pcix_wdata  <= req_wdata;
              local_cnt_r <= local_cnt_r + 16'h0001;
              state_r     <= ST_LOCAL;
            end else begin
              // the remote hub translates on its own side, so the address leaves whole
              remote_valid <= 1'b1;
              remote_addr  <= req_addr;
              remote_write <= req_write;
              remote_be    <= req_be;
              remote_wdata <= req_wdata;
              remote_cnt_r <= remote_cnt_r + 16'h0001;
              state_r      <= ST_REMOTE;
            end
          end
        end
        ST_LOCAL: begin
          if (pcix_ack) begin
            pcix_valid <= 1'b0;
            req_ready  <= 1'b1;
            rsp_valid  <= 1'b1;
            if (pcix_write) begin
              rsp_rdata <= 32'h0000_0000;
            end else begin
              rsp_rdata <= pcix_rdata;
            end
            state_r    <= ST_IDLE;
          end
        end
        ST_REMOTE: begin
          if (remote_ack) begin
            remote_valid <= 1'b0;
            req_ready    <= 1'b1;
            rsp_valid    <= 1'b1;
            if (remote_write) begin
              rsp_rdata <= 32'h0000_0000;
            end else begin
              rsp_rdata <= remote_rdata;
            end
            state_r      <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // pio_address_translator

// ---- bench/pio_xlate_asserts.sv ----
`timescale 1ns/1ps
module pio_xlate_asserts #(parameter ADDR_W = 50) (
  input wire mclk, rst, psel, penable, pwrite, pready, req_valid, req_write, req_ready,
  input wire rsp_valid, remote_valid, remote_ack, pcix_valid, pcix_write, pcix_ack,
  input wire [11:0] paddr,
  input wire [3:0] req_be, pcix_be,
  input wire [31:0] pwdata, rsp_rdata, pcix_addr, pcix_rdata,
  input wire [ADDR_W-1:0] req_addr, remote_addr
);
  reg [10:0] node_r;
  // software copy of the node number, needed to judge routing
  always @(posedge mclk)
    if (rst) node_r <= 11'h000;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) node_r <= pwdata[10:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  AST_APB_ONE: assert property (pready |=> !pready) else $error("long pready");
  AST_ROUTE: assert property ($rose(req_valid) |=> pcix_valid != remote_valid
    && pcix_valid == (req_addr[48:38] == node_r)) else $error("bad route");
  AST_LOW: assert property (pcix_valid |-> pcix_addr[19:0] == req_addr[19:0])
    else $error("low bits");
  AST_KEEP: assert property (pcix_valid |-> pcix_write == req_write && pcix_be == req_be)
    else $error("kind lost");
  AST_REMOTE: assert property (remote_valid |-> remote_addr == req_addr)
    else $error("remote addr");
  AST_HOLD: assert property (pcix_valid && !pcix_ack |=> pcix_valid) else $error("drop");
  AST_RET: assert property (pcix_valid && pcix_ack |=> req_ready && rsp_valid &&
    rsp_rdata == ($past(pcix_write) ? 32'h0 : $past(pcix_rdata))) else $error("rsp");
  cover property (remote_valid && remote_ack);
  cover property (pcix_valid && pcix_ack && pcix_write);
  cover property (pcix_valid && pcix_ack && !pcix_write);
endmodule // pio_xlate_asserts
bind pio_address_translator pio_xlate_asserts #(.ADDR_W(ADDR_W)) i_pio_xlate_asserts (.*);

// ---- bench/pio_far_model.sv ----
`timescale 1ns/1ps
module pio_far_model #(parameter W = 32) (
  input  wire         mclk,
  input  wire         rst,
  input  wire         valid,
  input  wire [W-1:0] addr,
  output reg          ack,
  output reg  [31:0]  rdata
);
  reg [1:0] wait_r;
  // idle data flips so a stale word never passes for an answer
  always @(posedge mclk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      rdata <= 32'h0;
      wait_r <= 2'h0;
    end else if (valid && !ack) begin
      if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
      else begin
        ack <= 1'b1;
        rdata <= addr[31:0] ^ 32'h5a5a_5a5a;
        wait_r <= 2'($urandom % 4);
      end
    end
  end
endmodule // pio_far_model

// ---- bench/pio_address_translator_tb.sv ----
`timescale 1ns/1ps
module pio_address_translator_tb;
  reg mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg req_valid = 1'b0, req_write = 1'b0, e, mem_m [0:15];
  reg [11:0] paddr = 12'h0, off_m [0:15];
  reg [31:0] pwdata = 32'h0, req_wdata = 32'h0, q, t;
  reg [49:0] req_addr = 50'h0, a;
  reg [3:0] req_be = 4'h0;
  reg [36:0] k;
  reg [10:0] node;
  wire [31:0] prdata, rsp_rdata, remote_wdata, pcix_addr, pcix_wdata, remote_rdata, pcix_rdata;
  wire [49:0] remote_addr;
  wire [3:0] remote_be, pcix_be;
  wire pready, pslverr, req_ready, rsp_valid, remote_valid, remote_write, remote_ack;
  wire pcix_valid, pcix_mem, pcix_write, pcix_ack;
  integer error_cnt = 0, checks = 0, i, lc = 0, rc = 0;
  pio_address_translator i_pio_address_translator (.*);
  pio_far_model i_pio_far_model (.mclk, .rst, .valid(pcix_valid), .addr(pcix_addr),
    .ack(pcix_ack), .rdata(pcix_rdata));
  pio_far_model #(.W(50)) i_pio_far_model_rem (.mclk, .rst, .valid(remote_valid),
    .addr(remote_addr), .ack(remote_ack), .rdata(remote_rdata));
  initial forever #2.5 mclk = ~mclk;
  task chk(input string n, input [49:0] seen, input [49:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      @(posedge mclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
    end
  endtask
  task pio;
    begin
      t = {off_m[a[23:20]], a[19:0]};
      @(posedge mclk);
      {req_valid, req_addr, req_write, req_be, req_wdata} <= {1'b1, a, 5'($urandom), $urandom};
      do @(posedge mclk); while (pcix_valid !== 1'b1 && remote_valid !== 1'b1);
      k = {req_write, req_be, req_wdata};
      if (a[48:38] != node) t = a[31:0];
      if (a[48:38] != node) rc = rc + 1;
      else lc = lc + 1;
      if (a[48:38] != node) chk("remote_addr", remote_addr, a);
      else chk("pcix_addr", pcix_addr, t);
      if (a[48:38] != node) chk("remote_kind", {remote_write, remote_be, remote_wdata}, k);
      else chk("pcix_kind", {pcix_write, pcix_be, pcix_wdata}, k);
      if (a[48:38] == node) chk("pcix_mem", pcix_mem, mem_m[a[23:20]]);
      do @(posedge mclk); while (req_ready !== 1'b1);
      chk("rsp_valid", rsp_valid, 1'b1);
      chk("rsp_rdata", rsp_rdata, req_write ? 32'h0 : t ^ 32'h5a5a_5a5a);
      req_valid <= 1'b0;
    end
  endtask
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    i = $urandom(7043);
    apb(1'b0, 12'h07c, 32'h0);
    chk("dev_rst", q, 32'h0);
    apb(1'b1, 12'h0fc, 32'h0);
    chk("slverr", e, 1'b1);
    node = 11'($urandom);
    apb(1'b1, 12'h000, {21'h0, node});
    apb(1'b0, 12'h000, 32'h0);
    chk("node", q, node);
    for (i = 0; i < 16; i = i + 1) begin
      {mem_m[i], off_m[i]} = (i == 4) ? 13'h01ff : 13'($urandom);
      apb(1'b1, 12'h040 + 12'(4 * i), {19'h0, mem_m[i], off_m[i]});
    end
    a = {1'b0, node, 6'h0, 32'h0e4f_0000};
    pio;
    apb(1'b0, 12'h008, 32'h0);
    chk("last_addr", q, 32'h1fff_0000);
    for (i = 0; i < 60; i = i + 1) begin
      a = 50'({$urandom, $urandom});
      a[48:38] = (i % 3 == 0) ? ~node : node;
      pio;
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("status", q, {13'h0, 3'b001, 16'(rc)});
    apb(1'b0, 12'h00c, 32'h0);
    chk("local_cnt", q, 32'(lc));
    conclude;
  end
endmodule // pio_address_translator_tb
